// ===== logic/sas_pkg.sv
// Shared constants and types for the successive approximation sequencer
`default_nettype none
package sas_pkg;
	localparam int unsigned SAS_WIDTH        = 8;
	localparam int unsigned SAS_CONV_CYCLES  = SAS_WIDTH + 1;
	localparam int unsigned SAS_CLK_PERIOD_PS = 4000;
	localparam int unsigned SAS_CONV_TIME_US = 6;
	localparam int unsigned SAS_CONV_MAX_CYC = (SAS_CONV_TIME_US * 1000 * 1000) / SAS_CLK_PERIOD_PS;
	localparam logic        SAS_START_RST    = 1'b1;
	localparam logic        SAS_DONE_N_RST   = 1'b1;
	localparam logic        SAS_SERIAL_RST   = 1'b0;

	typedef enum logic [1:0] {
		SAS_IDLE,
		SAS_ARM,
		SAS_TRIAL
	} sas_state_t;
endpackage : sas_pkg
`default_nettype wire

// ===== logic/sas_sync.sv
// Two-stage synchroniser for a level arriving from a pin
`default_nettype none
module sas_sync
	import sas_pkg::*;
#(
	parameter logic RST_VAL = SAS_START_RST
) (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic async_i,
	output logic      sync_o
);
	typedef struct packed {
		logic meta;
		logic sync;
	} sas_sync_st_t;

	sas_sync_st_t s_q;
	sas_sync_st_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.meta = async_i;
		// First stage is read by the second stage only
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			s_q.meta <= RST_VAL;
			s_q.sync <= RST_VAL;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_o = s_q.sync;
endmodule // sas_sync
`default_nettype wire

// ===== logic/sas_seq.sv
// Sequencer for an n-bit successive approximation converter
`default_nettype none
// What this block does
// [R1] A start request places one token at the first chain position, setting the MSB latch as the first trial.
// [R2] During a trial the bit is kept when the comparator is low and cleared otherwise before the next trial.
// [R3] Each following clock moves the token one place toward the LSB and starts that trial until all are tried.
// [R4] An n-bit conversion takes n+1 clock periods from start request to the completed indication.
// [R5] Every state change happens on a rising clock edge.
// [R6] The controller holds start low to begin, and the sequencer then drives the completed output high.
// [R7] After the last trial the final rising edge drives the completed output low, marking the result valid.
// [R8] Bit-select outputs go low during their trial and the converter data word is complementary binary.
// [R9] Each decided bit appears on the serial output in NRZ form after each rising edge, MSB first.
// [R10] The MSB result is given in both true and inverted form.
// [R11] A full 8-bit conversion fits within about 6 microseconds at the recommended clock.
// [R12] After completion the result latches hold steady until the next start request.
module sas_seq
	import sas_pkg::*;
#(
	parameter int unsigned WIDTH = SAS_WIDTH
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire logic             start_n_i,
	input  wire logic             comp_i,
	output logic [WIDTH-1:0]      bit_sel_n_o,
	output logic [WIDTH-1:0]      dac_data_n_o,
	output logic [WIDTH-1:0]      result_o,
	output logic                  msb_o,
	output logic                  msb_n_o,
	output logic                  serial_o,
	output logic                  conversion_done_n_o
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		sas_state_t       state;
		logic [WIDTH-1:0] tok;
		logic [WIDTH-1:0] sel_n;
		logic [WIDTH-1:0] res;
		logic [WIDTH-1:0] res_n;
		logic             ser;
		logic             done_n;
	} sas_seq_st_t;

	sas_seq_st_t      s_q;
	sas_seq_st_t      s_d;
	logic             start_n_sync;
	logic             start_req;
	logic [WIDTH-1:0] kept;
	logic [WIDTH-1:0] next_tok;

	// Start comes from a pin, so it is synchronised first
	sas_sync #(
		.RST_VAL (SAS_START_RST)
	) u_start_sync (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.async_i    (start_n_i),
		.sync_o     (start_n_sync)
	);

	assign start_req = ~start_n_sync;

	// Comparator is read directly: it must settle inside one clock, no time to synchronise it

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d      = s_q;
		kept     = s_q.res & ~(s_q.tok & {WIDTH{comp_i}}); // see [R2]
		next_tok = s_q.tok >> 1; // see [R3]
		case (s_q.state)
			SAS_IDLE: begin
				// Result held while idle, even as start stays high, see [R12]
				// Start held low restarts one cycle after done falls
				if (start_req) begin
					s_d.state  = SAS_ARM;
					s_d.done_n = 1'b1; // see [R6]
					s_d.res    = '0;
					s_d.res_n  = '1;
				end
			end
			SAS_ARM: begin
				// Arm cycle clears the result; costs one clock, giving n+1 periods
				s_d.state = SAS_TRIAL;
				s_d.tok   = {1'b1, {(WIDTH-1){1'b0}}}; // see [R1]
				s_d.res   = {1'b1, {(WIDTH-1){1'b0}}}; // see [R1]
				s_d.res_n = ~s_d.res; // see [R8]
			end
			SAS_TRIAL: begin
				s_d.ser   = ~comp_i; // see [R9]
				s_d.tok   = next_tok; // see [R3]
				s_d.res   = kept | next_tok;
				s_d.res_n = ~(kept | next_tok); // see [R8]
				if (s_q.tok[0]) begin
					// Last trial decided on this edge, see [R4]
					s_d.state  = SAS_IDLE;
					s_d.done_n = 1'b0; // see [R7]
				end
			end
			default: begin
				s_d.state = SAS_IDLE;
			end
		endcase
		// Select kept as its own flop so the pin has no gate after it
		s_d.sel_n = ~s_d.tok; // see [R8]
	end

	always_ff @(posedge core_clk_i) begin // see [R5]
		if (reset_i) begin
			s_q.state  <= SAS_IDLE;
			s_q.tok    <= '0;
			s_q.sel_n  <= '1;
			s_q.res    <= '0;
			s_q.res_n  <= '1;
			s_q.ser    <= SAS_SERIAL_RST;
			s_q.done_n <= SAS_DONE_N_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from state flops
	assign bit_sel_n_o         = s_q.sel_n; // see [R8]
	assign dac_data_n_o        = s_q.res_n;
	assign result_o            = s_q.res;
	assign msb_o               = s_q.res[WIDTH-1]; // see [R10]
	assign msb_n_o             = s_q.res_n[WIDTH-1]; // see [R10]
	assign serial_o            = s_q.ser;
	assign conversion_done_n_o = s_q.done_n;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence seq_start_taken;
		(s_q.state == SAS_IDLE) && start_req;
	endsequence

	sequence seq_conv_busy;
		conversion_done_n_o[*8];
	endsequence

	sequence seq_last_trial;
		(s_q.state == SAS_TRIAL) && s_q.tok[0];
	endsequence

	// Budget capped at 1000 cycles, far above the n+1 cycles a conversion needs
	localparam int CONV_BUDGET = int'((SAS_CONV_MAX_CYC > 32'd1000) ? 32'd1000 : SAS_CONV_MAX_CYC);

	AST_MSB_FIRST: assert property ( // see [R1]
		seq_start_taken |=> ##1 (bit_sel_n_o == ~{1'b1, {(WIDTH-1){1'b0}}}) && msb_o)
		else $error("MSB trial not first after start");

	AST_CLEAR_ON_HIGH: assert property ( // see [R2]
		(s_q.state == SAS_TRIAL) && comp_i |=> (result_o & ~$past(bit_sel_n_o)) == '0)
		else $error("Trial bit not cleared by high comparator");

	AST_KEEP_ON_LOW: assert property ( // see [R2]
		(s_q.state == SAS_TRIAL) && !comp_i |=> (result_o & ~$past(bit_sel_n_o)) == ~$past(bit_sel_n_o))
		else $error("Trial bit lost with low comparator");

	AST_TOKEN_STEP: assert property ( // see [R3]
		(s_q.state == SAS_TRIAL) |=> ~bit_sel_n_o == (~$past(bit_sel_n_o) >> 1))
		else $error("Token did not advance one place");

	AST_DONE_TIMING: assert property ( // see [R4]
		seq_start_taken |=> ##1 seq_conv_busy ##1 !conversion_done_n_o)
		else $error("Completion not at n+1 clocks");

	AST_DONE_RISES: assert property ( // see [R6]
		seq_start_taken |=> conversion_done_n_o)
		else $error("Completed output not high after start");

	AST_DONE_AFTER_LSB: assert property ( // see [R7]
		$fell(conversion_done_n_o) |-> $past(bit_sel_n_o[0]) == 1'b0 && bit_sel_n_o == '1)
		else $error("Completion not on the edge after LSB trial");

	AST_DAC_CODE: assert property ( // see [R8]
		dac_data_n_o == ~result_o && $countones(~bit_sel_n_o) <= 1)
		else $error("Converter word or bit select malformed");

	AST_SERIAL_BIT: assert property ( // see [R9]
		(s_q.state == SAS_TRIAL) |=> serial_o == ~$past(comp_i))
		else $error("Serial bit does not match decision");

	AST_MSB_PAIR: assert property ( // see [R10]
		msb_o != msb_n_o)
		else $error("MSB true and inverted disagree");

	AST_CONV_TIME: assert property ( // see [R11]
		seq_start_taken |-> ##[1:CONV_BUDGET] !conversion_done_n_o)
		else $error("Conversion exceeds time budget");

	AST_RESULT_HOLD: assert property ( // see [R12]
		!conversion_done_n_o && !start_req |=> $stable(result_o))
		else $error("Result changed before next start");

	AST_ARM_CLEARED: assert property ( // see [R1]
		(s_q.state == SAS_ARM) |-> result_o == '0 && bit_sel_n_o == '1)
		else $error("Arm cycle did not clear result and select");

	AST_LAST_STEP: assert property ( // see [R3]
		seq_last_trial |=> (s_q.state == SAS_IDLE) && bit_sel_n_o == '1)
		else $error("Sequencer did not stop after LSB trial");

	AST_START_IGNORED: assert property ( // see [R6]
		(s_q.state != SAS_IDLE) && start_req |=> s_q.state != SAS_ARM)
		else $error("Start accepted during a conversion");

	AST_RESTART: assert property ( // see [R6]
		!conversion_done_n_o && start_req |=> conversion_done_n_o)
		else $error("Start after completion not accepted");

	AST_DONE_IDLE: assert property ( // see [R7]
		!conversion_done_n_o |-> s_q.state == SAS_IDLE)
		else $error("Completed shown while converting");

	AST_SEL_IDLE: assert property ( // see [R8]
		(s_q.state == SAS_IDLE) |-> bit_sel_n_o == '1)
		else $error("Bit select active while idle");
endmodule // sas_seq
`default_nettype wire

// ===== verif/sas_comp_model.sv
// Behavioural comparator and current-output converter facing the sequencer
`default_nettype none
module sas_comp_model (
	input  wire logic [sas_pkg::SAS_WIDTH-1:0] dac_data_n_i,
	input  wire logic [sas_pkg::SAS_WIDTH-1:0] vin_i,
	output logic                               comp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import sas_pkg::*;
	// High when the trial word overshoots the input; settles well inside one cycle
	assign #1 comp_o = ((~dac_data_n_i) > vin_i);
endmodule // sas_comp_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking testbench for the successive approximation sequencer
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sas_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        reset_i    = 1'b1;
	logic        start_n_i  = 1'b1;
	logic        comp_i;
	logic [7:0]  vin        = 8'h00;
	logic [7:0]  bit_sel_n, dac_n, result;
	logic        msb, msb_n, serial, done_n;
	int          errors     = 0;
	int          checks     = 0;
	int unsigned rng        = 8;
	always #2 core_clk_i = ~core_clk_i;
	sas_seq sas_seq_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .start_n_i(start_n_i), .comp_i(comp_i),
		.bit_sel_n_o(bit_sel_n), .dac_data_n_o(dac_n), .result_o(result), .msb_o(msb), .msb_n_o(msb_n),
		.serial_o(serial), .conversion_done_n_o(done_n));
	sas_comp_model sas_comp_model_i (.dac_data_n_i(dac_n), .vin_i(vin), .comp_o(comp_i));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] sar(int v);
		int e;
		e = 0;
		for (int b = 7; b >= 0; b--) begin
			if ((e | (1 << b)) <= v) begin
				e = e | (1 << b);
			end
		end
		return e[7:0];
	endfunction
	task automatic end_of_test;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	function automatic int unsigned xorshift(int unsigned s);
		int unsigned r;
		r = s ^ (s << 13);
		r = r ^ (r >> 17);
		r = r ^ (r << 5);
		return r;
	endfunction
	// Start is held a few cycles; repeats inside a conversion must be ignored
	task automatic convert(logic [7:0] v, bit first);
		int         n;
		logic [7:0] e;
		logic [7:0] prev_sel;
		vin = v;
		e   = sar(int'(v));
		n   = 0;
		prev_sel = 8'hff;
		start_n_i = 1'b0;
		for (int i = 0; i < 40 && !(n > 0 && done_n === 1'b0); i++) begin
			@(negedge core_clk_i);
			if (i == 3) start_n_i = 1'b1;
			if (done_n === 1'b1) n++;
			`CHK("bit_sel", 1'b1, $onehot0(~bit_sel_n))
			// Bit tried in the previous cycle is the one shown now, MSB first
			for (int b = 0; b < 8; b++) begin
				if (prev_sel[b] === 1'b0) `CHK("serial", e[b], serial)
			end
			prev_sel = bit_sel_n;
		end
		if (done_n !== 1'b0) begin
			errors++;
			end_of_test();
		end
		if (!first) `CHK("done_cycles", SAS_CONV_CYCLES, n)
		`CHK("result", e, result)
		`CHK("dac", ~e, dac_n)
		`CHK("msb", e[7], msb)
		`CHK("msb_n", ~e[7], msb_n)
		`CHK("serial_lsb", e[0], serial)
		vin = ~v;
		repeat (4) @(negedge core_clk_i);
		`CHK("held", e, result)
		`CHK("done_held", 1'b0, done_n)
	endtask
	initial begin
		repeat (16) @(negedge core_clk_i);
		`CHK("rst_done", 1'b1, done_n)
		`CHK("rst_sel", 8'hff, bit_sel_n)
		reset_i = 1'b0;
		@(negedge core_clk_i);
		convert(8'h00, 1'b1);
		convert(8'hff, 1'b0);
		convert(8'h80, 1'b0);
		convert(8'h7f, 1'b0);
		for (int k = 0; k < 12; k++) begin
			rng = xorshift(rng);
			convert(rng[7:0], 1'b0);
		end
		// Reset in mid conversion must abandon it and show idle outputs
		start_n_i = 1'b0;
		repeat (6) @(negedge core_clk_i);
		reset_i   = 1'b1;
		start_n_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		`CHK("mid_rst_done", 1'b1, done_n)
		`CHK("mid_rst_sel", 8'hff, bit_sel_n)
		`CHK("mid_rst_dac", 8'hff, dac_n)
		reset_i = 1'b0;
		@(negedge core_clk_i);
		convert(8'h5a, 1'b1);
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
